// ==== shared/recovered_clock_map.svh ====
// Address map, field positions, source codes and divider codes of the
// recovered clock selector. Included by every design file that needs them.
// How it works
// [RULE_01] Eight channels; channels 0-3 drive pins, channels 4-7 feed timing recovery.
// [RULE_02] Each channel divides its source by 1, 2, 4, 5, 8, 16 or 25.
// [RULE_03] Software uses divider code 6 (125 MHz) only on channels 4-7.
// [RULE_04] Software uses divider code 1 (31.25 MHz); only choice on pin channels.
// [RULE_05] Any 10/100/1000 Mbps stream recovers; 2.5 Gbps only on ports 5 and 6.
// [RULE_06] Copper PHY source value equals PHY index; channel enable must be 1.
// [RULE_07] Software sets PHY control enable, source, frequency and select bits to 1/index.
// [RULE_08] SerDes lanes 0 to 6 are selected by lane index plus 4.
// [RULE_09] Source 12 picks the first PLL, source 21 the second PLL.
// [RULE_10] Pin channels 0-3 are an alternate function of general-purpose pins.
// [RULE_11] PLL clocks leave on two high-speed outputs; select field copies core.
// [RULE_12] A channel squelches automatically when its selected source loses signal; the code never squelches PHY sources 0-1.
// [RULE_13] Sources 4-8 squelch under the 1G macro enable at index source minus 4.
// [RULE_14] Sources 9-10 squelch under the 6G macro enable at index source minus 9.
// [RULE_15] Source 12 squelches on first PLL lock loss when PLL config 0 enables.
// [RULE_16] Source 21 squelches on second PLL lock loss when PLL config 1 enables.
// [RULE_17] A squelched output stops, held static high or low, while loss lasts.
// [RULE_18] On recovery the channel restarts cleanly, with no runt pulses.
`ifndef RECOVERED_CLOCK_MAP_SVH
`define RECOVERED_CLOCK_MAP_SVH

`define NUM_CHANNELS 8
`define NUM_PIN_CHANNELS 4

// Register byte addresses
`define CH_CFG_REGION 3'h0
`define PLL_CFG0_OFFSET 8'h20
`define PLL_CFG1_OFFSET 8'h24
`define HS_OUT_CFG_OFFSET 8'h28
`define ONE_GIG_CFG_OFFSET 8'h2C
`define SIX_GIG_CFG_OFFSET 8'h30
`define PHY_CTRL0_OFFSET 8'h34
`define PHY_CTRL1_OFFSET 8'h38
`define GPIO_CFG_OFFSET 8'h3C
`define STATUS_OFFSET 8'h40

// Field positions
`define CH_ENABLE_BIT 0
`define CH_DIV_LSB 1
`define CH_DIV_MSB 3
`define CH_SRC_LSB 4
`define CH_SRC_MSB 8
`define HS_A_LSB 0
`define HS_B_LSB 2
`define GPIO_ALT_LSB 0
`define GPIO_DATA_LSB 8
`define GPIO_DIR_LSB 16
`define ST_SQUELCH_LSB 0
`define ST_LEVEL_LSB 8
`define ST_ONE_LOST_LSB 16
`define ST_SIX_LOST_LSB 21
`define ST_LOCK_LSB 23

// Source select codes
`define SRC_PHY_LAST 5'h01
`define SRC_ONE_GIG_FIRST 5'h04
`define SRC_ONE_GIG_LAST 5'h08
`define SRC_SIX_GIG_FIRST 5'h09
`define SRC_SIX_GIG_LAST 5'h0A
`define SRC_PLL_FIRST 5'h0C
`define SRC_PLL_SECOND 5'h15

// Divider codes and divisors
`define DIV_CODE_BY2 3'h0
`define DIV_CODE_BY4 3'h1
`define DIV_CODE_BY5 3'h2
`define DIV_CODE_BY8 3'h3
`define DIV_CODE_BY16 3'h4
`define DIV_CODE_BY25 3'h5
`define DIV_CODE_BY1 3'h6

`endif

// ==== shared/recovered_clock_pkg.sv ====
// Types shared by the recovered clock selector and its channel module.
// Assumes eight channels and four pin channels, as in the map header; widths are literals here.
package recovered_clock_pkg;

    typedef struct packed {
        logic [4:0] source;
        logic [2:0] divider;
        logic enable;
    } channel_cfg_t;

    typedef struct packed {
        logic select_bit;
        logic frequency_select;
        logic source_select;
        logic enable;
    } phy_ctrl_t;

    typedef enum logic [1:0] {
        HS_OFF,
        HS_CORE_COPY,
        HS_PLL_DIRECT
    } hs_select_t;

    typedef struct packed {
        logic prev;
        logic running;
        logic [4:0] count;
        logic out;
        logic squelched;
    } channel_state_t;

    typedef struct packed {
        channel_cfg_t [7:0] chan;
        logic [1:0] pll_squelch_en;
        logic [1:0] hs_sel_a;
        logic [1:0] hs_sel_b;
        logic [4:0] one_gig_squelch_en;
        logic [1:0] six_gig_squelch_en;
        phy_ctrl_t [1:0] phy;
        logic [3:0] gpio_alt;
        logic [3:0] gpio_data;
        logic [3:0] gpio_dir;
        logic [19:0] sync1;
        logic [19:0] sync2;
        logic core_toggle;
        logic hs_out_a;
        logic hs_out_b;
        logic [3:0] pin_out;
        logic [3:0] pin_oe;
        logic [3:0] internal_clk;
        logic [31:0] rdata;
    } selector_state_t;

endpackage

// ==== testbench/recovered_clock_checker.sv ====
// Port-level checks on the recovered clock selector; bound to its top module.
// Assumes software reaches channel 4 and the enables through the register port.
`timescale 1ns/10ps
module recovered_clock_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic [31:0] rdata,
    input wire logic [4:0] one_gig_signal_lost,
    input wire logic [1:0] six_gig_signal_lost,
    input wire logic [1:0] pll_locked,
    input wire logic [3:0] recovered_clock_out_pin_oe,
    input wire logic [3:0] timing_recovery_clock,
    input wire logic pll_high_speed_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [8:0] ch4_reg;
    logic [1:0] pll_en_reg, six_en_reg, hs_a_reg;
    logic [4:0] one_en_reg, src;
    logic [3:0] alt_reg, since_reg, lost_reg;
    logic lost_sel, bad_src, settled;
    assign src = ch4_reg[8:4];
    assign settled = since_reg >= 4'h6;
    assign bad_src = src inside {5'h02, 5'h03, 5'h0B} || (src >= 5'h0D && src != 5'h15);
    always_comb begin
        lost_sel = 1'b0;
        if (src >= 5'h04 && src <= 5'h08) begin
            lost_sel = one_gig_signal_lost[src - 5'h04] && one_en_reg[src - 5'h04];
        end
        if (src == 5'h09 || src == 5'h0A) begin
            lost_sel = six_gig_signal_lost[~src[0]] && six_en_reg[~src[0]];
        end
        if (src == 5'h0C) begin
            lost_sel = !pll_locked[0] && pll_en_reg[0];
        end
        if (src == 5'h15) begin
            lost_sel = !pll_locked[1] && pll_en_reg[1];
        end
    end
    // Any write restarts the settle count, since outputs lag config by a few edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ch4_reg <= '0;
            pll_en_reg <= '0;
            six_en_reg <= '0;
            hs_a_reg <= '0;
            one_en_reg <= '0;
            alt_reg <= '0;
            since_reg <= '0;
            lost_reg <= '0;
        end else begin
            since_reg <= wr_strobe ? 4'h0 : since_reg + 4'(since_reg != 4'hF);
            lost_reg <= (!lost_sel || wr_strobe) ? 4'h0 : lost_reg + 4'(lost_reg != 4'hF);
            if (wr_strobe) begin
                case (addr)
                    8'h10: ch4_reg <= wdata[8:0];
                    8'h20: pll_en_reg[0] <= wdata[0];
                    8'h24: pll_en_reg[1] <= wdata[0];
                    8'h28: hs_a_reg <= wdata[1:0];
                    8'h2C: one_en_reg <= wdata[4:0];
                    8'h30: six_en_reg <= wdata[1:0];
                    8'h3C: alt_reg <= wdata[3:0];
                    default: ;
                endcase
            end
        end
    end
    a_rdata_idle: assert property (!rd_strobe |=> rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_squelch_hold: assert property (lost_reg >= 4'h7 |-> $stable(timing_recovery_clock[0]))
        else $error("squelched channel output moved");
    a_disabled_low: assert property (!ch4_reg[0] && settled |-> !timing_recovery_clock[0])
        else $error("disabled channel drives a clock");
    a_bad_source_low: assert property (bad_src && settled |-> !timing_recovery_clock[0])
        else $error("unused source code drives a clock");
    a_pin_alt_drive: assert property (alt_reg[0] && settled |-> recovered_clock_out_pin_oe[0])
        else $error("pin not driven in alternate function");
    a_hs_off_low: assert property (hs_a_reg[0] == hs_a_reg[1] && settled |-> !pll_high_speed_out)
        else $error("high-speed output active while off");
    a_hs_core_copy: assert property (hs_a_reg == 2'h1 && settled |-> pll_high_speed_out != $past(pll_high_speed_out))
        else $error("core copy output not toggling");
    a_status_lock: assert property ($stable(pll_locked) [*4] ##0 (rd_strobe && addr == 8'h40)
        |=> rdata[24:23] == $past(pll_locked))
        else $error("lock status not reported");
    c_squelch: cover property (lost_reg == 4'hF);
    c_hs_direct: cover property (hs_a_reg == 2'h2 && $rose(pll_high_speed_out));
    c_pin_clock: cover property (alt_reg[0] && $rose(recovered_clock_out_pin_oe[0]));
endmodule
bind recovered_clock_select_squelch recovered_clock_checker u_chk (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rdata(rdata), .one_gig_signal_lost(one_gig_signal_lost),
    .six_gig_signal_lost(six_gig_signal_lost), .pll_locked(pll_locked),
    .recovered_clock_out_pin_oe(recovered_clock_out_pin_oe),
    .timing_recovery_clock(timing_recovery_clock), .pll_high_speed_out(pll_high_speed_out)
);

// ==== testbench/source_model.sv ====
// Line-side clock sources: PHYs, SerDes lanes and PLLs with loss indications.
// Source i has a half period of 4+i system clocks, off the system clock edges.
`timescale 1ns/10ps
module source_model (
    input wire logic [10:0] lose,
    output logic [1:0] phy_rx_clock,
    output logic [4:0] one_gig_rx_clock,
    output logic [1:0] six_gig_rx_clock,
    output logic [1:0] pll_clock,
    output logic [4:0] one_gig_signal_lost,
    output logic [1:0] six_gig_signal_lost,
    output logic [1:0] pll_locked
);
    logic [10:0] clks;
    // Clocks keep running during a loss, so only a real squelch stops the output
    for (genvar i = 0; i < 11; i++) begin : g_src
        initial begin
            clks[i] = 1'b0;
            #(3 + i);
            forever #(25 * (4 + i)) clks[i] = ~clks[i];
        end
    end
    assign {pll_clock, six_gig_rx_clock, one_gig_rx_clock, phy_rx_clock} = clks;
    assign one_gig_signal_lost = lose[6:2];
    assign six_gig_signal_lost = lose[8:7];
    assign pll_locked = ~lose[10:9];
endmodule

// ==== testbench/tb_recovered_clock_select_squelch.sv ====
// Self-checking bench for the recovered clock selector.
// Assumes the source model periods: source i runs at 8+2i system clocks.
`timescale 1ns/10ps
module tb_recovered_clock_select_squelch;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, d;
    logic [10:0] lose = 11'h0;
    logic [1:0] phy_rx_clock, six_gig_rx_clock, pll_clock, six_gig_signal_lost, pll_locked;
    logic [4:0] one_gig_rx_clock, one_gig_signal_lost;
    logic [3:0] pin_out, pin_oe, trc;
    logic hs_a, hs_b;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    int p, h, f, m;
    always #12.5 clk = ~clk;
    source_model u_src (.lose(lose), .phy_rx_clock(phy_rx_clock),
        .one_gig_rx_clock(one_gig_rx_clock), .six_gig_rx_clock(six_gig_rx_clock),
        .pll_clock(pll_clock), .one_gig_signal_lost(one_gig_signal_lost),
        .six_gig_signal_lost(six_gig_signal_lost), .pll_locked(pll_locked));
    recovered_clock_select_squelch u_dut (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
        .phy_rx_clock(phy_rx_clock), .one_gig_rx_clock(one_gig_rx_clock),
        .six_gig_rx_clock(six_gig_rx_clock), .pll_clock(pll_clock),
        .one_gig_signal_lost(one_gig_signal_lost), .six_gig_signal_lost(six_gig_signal_lost),
        .pll_locked(pll_locked), .recovered_clock_out_pin_out(pin_out),
        .recovered_clock_out_pin_oe(pin_oe), .timing_recovery_clock(trc),
        .pll_high_speed_out(hs_a), .second_pll_high_speed_out(hs_b));
    task automatic print_verdict;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_strobe <= 1'b1;
        @(posedge clk);
        wr_strobe <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1;
        v = rdata;
    endtask
    function automatic logic sig(input int i);
        if (i < 4) return pin_out[i];
        if (i < 8) return trc[i - 4];
        return (i == 8) ? hs_a : hs_b;
    endfunction
    // Waits out two rising edges first, so a phase cut short by reconfiguration is not measured
    task automatic meas(input int i, output int per, output int hi);
        int n;
        repeat (2) begin
            for (n = 0; n < 2000 && sig(i) !== 1'b0; n++) tick();
            for (n = 0; n < 2000 && sig(i) !== 1'b1; n++) tick();
        end
        for (hi = 0; hi < 2000 && sig(i) === 1'b1; hi++) tick();
        for (per = hi; per < 2000 && sig(i) === 1'b0; per++) tick();
    endtask
    task automatic runs(input int i, input int n, output int flips, output int mn);
        logic v;
        int run;
        v = sig(i);
        run = 0;
        flips = 0;
        mn = 999;
        repeat (n) begin
            tick();
            run++;
            if (sig(i) !== v) begin
                flips++;
                if (flips > 1 && run < mn) mn = run;
                run = 0;
                v = sig(i);
            end
        end
    endtask
    task automatic t_regs;
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10, d);
        chk("channel config", 32'h0000_01FF, d);
        rd(8'h40, d);
        chk("status after reset", 32'h0180_0000, d);
        wr(8'h44, 32'hFFFF_FFFF);
        rd(8'h44, d);
        chk("unmapped read", 32'h0, d);
        rd(8'h11, d);
        chk("misaligned read", 32'h0, d);
    endtask
    task automatic t_div;
        int dv[8] = '{2, 4, 5, 8, 16, 25, 1, 1};
        for (int c = 0; c < 8; c++) begin
            wr(8'h10, 32'h41 | 32'(c << 1));
            meas(4, p, h);
            chk("divided period", 32'(dv[c] * 12), 32'(p));
            chk("divided high", 32'(dv[c] == 1 ? 6 : (dv[c] / 2) * 12), 32'(h));
        end
    endtask
    task automatic t_src;
        int sc[11] = '{0, 1, 4, 5, 6, 7, 8, 9, 10, 12, 21};
        int bad[5] = '{2, 3, 11, 13, 22};
        wr(8'h34, 32'hF);
        wr(8'h38, 32'hF);
        for (int k = 0; k < 11; k++) begin
            wr(8'h10, 32'(sc[k] << 4) | 32'hD);
            meas(4, p, h);
            chk("source period", 32'(8 + 2 * k), 32'(p));
        end
        foreach (bad[k]) begin
            wr(8'h10, 32'(bad[k] << 4) | 32'hD);
            repeat (20) tick();
            chk("unused source", 32'h0, 32'(sig(4)));
        end
        wr(8'h10, 32'hCC);
        repeat (20) tick();
        chk("disabled channel", 32'h0, 32'(sig(4)));
    endtask
    task automatic t_sq(input int src, input logic [7:0] ea, input int ev, input int li,
                        input bit en);
        wr(ea, 32'(ev));
        wr(8'h10, 32'(src << 4) | 32'hD);
        repeat (40) tick();
        lose[li] <= 1'b1;
        repeat (10) tick();
        runs(4, 40, f, m);
        chk("toggling during loss", 32'(!en), 32'(f != 0));
        rd(8'h40, d);
        chk("squelch flag", 32'(en), 32'(d[4]));
        lose[li] <= 1'b0;
        runs(4, 80, f, m);
        chk("shortest phase", 32'(4 + li), 32'(m));
        wr(ea, 32'h0);
    endtask
    task automatic t_pins;
        wr(8'h3C, 32'hF);
        for (int c = 0; c < 8; c++) wr(8'(c * 4), c < 4 ? 32'hC3 : 32'hCD);
        for (int c = 0; c < 8; c++) begin
            meas(c, p, h);
            chk("channel period", 32'(c < 4 ? 104 : 26), 32'(p));
        end
        chk("pin enable", 32'hF, 32'(pin_oe));
        wr(8'h3C, 32'h0);
        repeat (4) tick();
        chk("pin released", 32'h0, 32'(pin_oe));
        wr(8'h3C, 32'h000F_0500);
        repeat (4) tick();
        chk("gpio drive", 32'hF5, 32'({pin_oe, pin_out}));
    endtask
    task automatic t_hs;
        wr(8'h28, 32'h1);
        repeat (6) tick();
        runs(8, 8, f, m);
        chk("core copy flips", 32'd8, 32'(f));
        wr(8'h28, 32'hA);
        meas(8, p, h);
        chk("first pll out", 32'd26, 32'(p));
        meas(9, p, h);
        chk("second pll out", 32'd28, 32'(p));
        wr(8'h28, 32'hF);
        repeat (6) tick();
        chk("outputs off", 32'h0, 32'({hs_a, hs_b}));
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_div();
        t_src();
        t_sq(4, 8'h2C, 1, 2, 1'b1);
        t_sq(8, 8'h2C, 16, 6, 1'b1);
        t_sq(4, 8'h2C, 2, 2, 1'b0);
        t_sq(9, 8'h30, 1, 7, 1'b1);
        t_sq(10, 8'h30, 2, 8, 1'b1);
        t_sq(12, 8'h20, 1, 9, 1'b1);
        t_sq(12, 8'h20, 0, 9, 1'b0);
        t_sq(21, 8'h24, 1, 10, 1'b1);
        t_pins();
        t_hs();
        print_verdict();
    end
endmodule

// ==== verilog/recovered_channel.sv ====
// One recovered clock channel: divider, enable and squelch hold.
// Assumes the source level is already synchronised to clk.
`timescale 1ns/10ps
`include "recovered_clock_map.svh"

module recovered_channel
    import recovered_clock_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic [2:0] divider_code,
    input wire logic source_level,
    input wire logic source_valid,
    input wire logic squelch,
    output logic clock_out,
    output logic squelched
);

    channel_state_t s;
    channel_state_t n;
    logic [4:0] divisor;
    logic [4:0] half;
    logic rise;

    always_comb begin
        unique case (divider_code)
            `DIV_CODE_BY2: divisor = 5'h02; // [RULE_02]
            `DIV_CODE_BY4: divisor = 5'h04;
            `DIV_CODE_BY5: divisor = 5'h05;
            `DIV_CODE_BY8: divisor = 5'h08;
            `DIV_CODE_BY16: divisor = 5'h10;
            `DIV_CODE_BY25: divisor = 5'h19;
            default: divisor = 5'h01;
        endcase
    end

    assign half = divisor >> 1;
    assign rise = source_level & ~s.prev;

    always_comb begin
        n = s;
        n.prev = source_level;
        n.squelched = enable & source_valid & squelch;
        if (!enable || !source_valid) begin
            // [RULE_06]
            n.running = 1'b0;
            n.count = 5'h00;
            n.out = 1'b0;
        end else if (squelch) begin
            // Output frozen at whatever level it had [RULE_17]
            n.running = 1'b0;
            n.count = 5'h00;
        end else if (divisor == 5'h01) begin
            // Follow only from a rising edge so a resume never cuts a high phase [RULE_18]
            if (rise) begin
                n.running = 1'b1;
            end
            if (rise || s.running) begin
                n.out = source_level;
            end
        end else if (rise) begin
            // Count restarts at zero after squelch, so the first phase is whole [RULE_18]
            n.running = 1'b1;
            n.out = (s.count < half);
            n.count = (s.count >= divisor - 5'h01) ? 5'h00 : s.count + 5'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign clock_out = s.out;
    assign squelched = s.squelched;

endmodule

// ==== verilog/recovered_clock_select_squelch.sv ====
// Recovered clock selection, division and automatic squelch for eight
// channels, plus GPIO overlay and the two high-speed PLL outputs.
// Assumes source clocks and status lines are asynchronous to clk and a
// register master using the plain one-cycle strobe port.
`timescale 1ns/10ps
`include "recovered_clock_map.svh"

module recovered_clock_select_squelch
    import recovered_clock_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [31:0] rdata,
    input wire logic [1:0] phy_rx_clock,
    input wire logic [4:0] one_gig_rx_clock,
    input wire logic [1:0] six_gig_rx_clock,
    input wire logic [1:0] pll_clock,
    input wire logic [4:0] one_gig_signal_lost,
    input wire logic [1:0] six_gig_signal_lost,
    input wire logic [1:0] pll_locked,
    output logic [3:0] recovered_clock_out_pin_out,
    output logic [3:0] recovered_clock_out_pin_oe,
    output logic [3:0] timing_recovery_clock,
    output logic pll_high_speed_out,
    output logic second_pll_high_speed_out
);

    selector_state_t s;
    selector_state_t n;

    // Synchronised copies, read only from the second stage
    logic [1:0] lock_s;
    logic [1:0] six_lost_s;
    logic [4:0] one_lost_s;
    logic [1:0] pll_clk_s;
    logic [1:0] six_clk_s;
    logic [4:0] one_clk_s;
    logic [1:0] phy_clk_s;

    logic [7:0] chan_clk;
    logic [7:0] chan_squelched;

    assign {lock_s, six_lost_s, one_lost_s, pll_clk_s, six_clk_s, one_clk_s, phy_clk_s} = s.sync2;

    // Per-channel source multiplexer and squelch decision
    for (genvar c = 0; c < `NUM_CHANNELS; c++) begin : g_chan
        logic [4:0] src;
        logic [4:0] one_idx;
        logic [4:0] six_idx;
        logic level;
        logic valid;
        logic squelch;

        assign src = s.chan[c].source;
        assign one_idx = src - `SRC_ONE_GIG_FIRST;
        assign six_idx = src - `SRC_SIX_GIG_FIRST;

        always_comb begin
            level = 1'b0;
            valid = 1'b0;
            squelch = 1'b0;
            if (src <= `SRC_PHY_LAST) begin
                // Copper PHY passes its clock only once its own control is set [RULE_06] [RULE_07]
                valid = s.phy[src[0]].enable & s.phy[src[0]].select_bit;
                level = phy_clk_s[src[0]];
            end else if (src >= `SRC_ONE_GIG_FIRST && src <= `SRC_ONE_GIG_LAST) begin
                // [RULE_08]
                valid = 1'b1;
                level = one_clk_s[one_idx[2:0]];
                // [RULE_12] [RULE_13]
                squelch = s.one_gig_squelch_en[one_idx[2:0]] & one_lost_s[one_idx[2:0]];
            end else if (src >= `SRC_SIX_GIG_FIRST && src <= `SRC_SIX_GIG_LAST) begin
                // 2.5 Gbps lanes sit only here [RULE_05] [RULE_08]
                valid = 1'b1;
                level = six_clk_s[six_idx[0]];
                // [RULE_12] [RULE_14]
                squelch = s.six_gig_squelch_en[six_idx[0]] & six_lost_s[six_idx[0]];
            end else if (src == `SRC_PLL_FIRST) begin
                // [RULE_09]
                valid = 1'b1;
                level = pll_clk_s[0];
                squelch = s.pll_squelch_en[0] & ~lock_s[0]; // [RULE_15]
            end else if (src == `SRC_PLL_SECOND) begin
                // [RULE_09]
                valid = 1'b1;
                level = pll_clk_s[1];
                squelch = s.pll_squelch_en[1] & ~lock_s[1]; // [RULE_16]
            end
        end

        recovered_channel u_channel (
            .clk(clk),
            .rst(rst),
            .enable(s.chan[c].enable),
            .divider_code(s.chan[c].divider),
            .source_level(level),
            .source_valid(valid),
            .squelch(squelch),
            .clock_out(chan_clk[c]),
            .squelched(chan_squelched[c])
        );
    end

    // Register write decode, output muxing and read data
    always_comb begin
        n = s;

        n.sync1 = {pll_locked, six_gig_signal_lost, one_gig_signal_lost,
                   pll_clock, six_gig_rx_clock, one_gig_rx_clock, phy_rx_clock};
        n.sync2 = s.sync1;

        // Stands in for the core clock at half the system rate
        n.core_toggle = ~s.core_toggle;

        if (wr_strobe) begin
            if (addr[7:5] == `CH_CFG_REGION && addr[1:0] == 2'h0) begin
                n.chan[addr[4:2]].enable = wdata[`CH_ENABLE_BIT];
                n.chan[addr[4:2]].divider = wdata[`CH_DIV_MSB:`CH_DIV_LSB];
                n.chan[addr[4:2]].source = wdata[`CH_SRC_MSB:`CH_SRC_LSB];
            end else begin
                case (addr)
                    `PLL_CFG0_OFFSET: n.pll_squelch_en[0] = wdata[0];
                    `PLL_CFG1_OFFSET: n.pll_squelch_en[1] = wdata[0];
                    `HS_OUT_CFG_OFFSET: begin
                        n.hs_sel_a = wdata[`HS_A_LSB +: 2];
                        n.hs_sel_b = wdata[`HS_B_LSB +: 2];
                    end
                    `ONE_GIG_CFG_OFFSET: n.one_gig_squelch_en = wdata[4:0];
                    `SIX_GIG_CFG_OFFSET: n.six_gig_squelch_en = wdata[1:0];
                    `PHY_CTRL0_OFFSET: n.phy[0] = wdata[3:0];
                    `PHY_CTRL1_OFFSET: n.phy[1] = wdata[3:0];
                    `GPIO_CFG_OFFSET: begin
                        n.gpio_alt = wdata[`GPIO_ALT_LSB +: 4];
                        n.gpio_data = wdata[`GPIO_DATA_LSB +: 4];
                        n.gpio_dir = wdata[`GPIO_DIR_LSB +: 4];
                    end
                    default: ;
                endcase
            end
        end

        // Pin channels override the GPIO driver when their alternate function is on
        for (int p = 0; p < `NUM_PIN_CHANNELS; p++) begin
            n.pin_out[p] = s.gpio_alt[p] ? chan_clk[p] : s.gpio_data[p]; // [RULE_10] [RULE_01]
            n.pin_oe[p] = s.gpio_alt[p] | s.gpio_dir[p]; // [RULE_10]
        end

        // [RULE_01]
        n.internal_clk = chan_clk[7:4];

        // [RULE_11]
        unique case (hs_select_t'(s.hs_sel_a))
            HS_CORE_COPY: n.hs_out_a = s.core_toggle;
            HS_PLL_DIRECT: n.hs_out_a = pll_clk_s[0];
            default: n.hs_out_a = 1'b0;
        endcase
        unique case (hs_select_t'(s.hs_sel_b))
            HS_CORE_COPY: n.hs_out_b = s.core_toggle;
            HS_PLL_DIRECT: n.hs_out_b = pll_clk_s[1];
            default: n.hs_out_b = 1'b0;
        endcase

        // Read data stand only in the cycle after the strobe
        n.rdata = 32'h0000_0000;
        if (rd_strobe) begin
            if (addr[7:5] == `CH_CFG_REGION && addr[1:0] == 2'h0) begin
                n.rdata[`CH_ENABLE_BIT] = s.chan[addr[4:2]].enable;
                n.rdata[`CH_DIV_MSB:`CH_DIV_LSB] = s.chan[addr[4:2]].divider;
                n.rdata[`CH_SRC_MSB:`CH_SRC_LSB] = s.chan[addr[4:2]].source;
            end else begin
                case (addr)
                    `PLL_CFG0_OFFSET: n.rdata[0] = s.pll_squelch_en[0];
                    `PLL_CFG1_OFFSET: n.rdata[0] = s.pll_squelch_en[1];
                    `HS_OUT_CFG_OFFSET: begin
                        n.rdata[`HS_A_LSB +: 2] = s.hs_sel_a;
                        n.rdata[`HS_B_LSB +: 2] = s.hs_sel_b;
                    end
                    `ONE_GIG_CFG_OFFSET: n.rdata[4:0] = s.one_gig_squelch_en;
                    `SIX_GIG_CFG_OFFSET: n.rdata[1:0] = s.six_gig_squelch_en;
                    `PHY_CTRL0_OFFSET: n.rdata[3:0] = s.phy[0];
                    `PHY_CTRL1_OFFSET: n.rdata[3:0] = s.phy[1];
                    `GPIO_CFG_OFFSET: begin
                        n.rdata[`GPIO_ALT_LSB +: 4] = s.gpio_alt;
                        n.rdata[`GPIO_DATA_LSB +: 4] = s.gpio_data;
                        n.rdata[`GPIO_DIR_LSB +: 4] = s.gpio_dir;
                    end
                    `STATUS_OFFSET: begin
                        n.rdata[`ST_SQUELCH_LSB +: 8] = chan_squelched;
                        n.rdata[`ST_LEVEL_LSB +: 8] = chan_clk;
                        n.rdata[`ST_ONE_LOST_LSB +: 5] = one_lost_s;
                        n.rdata[`ST_SIX_LOST_LSB +: 2] = six_lost_s;
                        n.rdata[`ST_LOCK_LSB +: 2] = lock_s;
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign rdata = s.rdata;
    assign recovered_clock_out_pin_out = s.pin_out;
    assign recovered_clock_out_pin_oe = s.pin_oe;
    assign timing_recovery_clock = s.internal_clk;
    assign pll_high_speed_out = s.hs_out_a;
    assign second_pll_high_speed_out = s.hs_out_b;

endmodule
